//--- inc/pmc_params.svh
// Named offsets, reset values, field positions and timing figures of the PLL margin block.
// Assumes it is included by bare name in every file that needs these constants.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_ADDR_STEP8_LOW   8'h67
`define PMC_ADDR_SOFT_HIGH   8'h68
`define PMC_ADDR_SOFT_LOW    8'h69
`define PMC_ADDR_STRETCH     8'h75
`define PMC_ADDR_FILTER      8'h76
`define PMC_ADDR_CAL_WAIT    8'h77
`define PMC_RST_STEP8_LOW    8'h9E
`define PMC_RST_SOFT_HIGH    2'h0
`define PMC_RST_SOFT_LOW     8'h00
`define PMC_RST_STRETCH      1'h0
`define PMC_RST_FILTER       3'h3
`define PMC_RST_CLSD_WAIT    2'h0
`define PMC_RST_VCO_WAIT     2'h1
`define PMC_RD_ZERO          8'h00
`define PMC_STRETCH_BIT      7
`define PMC_SOFT_HIGH_MSB    1
`define PMC_FILTER_MSB       2
`define PMC_CLSD_MSB         3
`define PMC_CLSD_LSB         2
`define PMC_VCO_MSB          1
`define PMC_VCO_LSB          0
`define PMC_MODE_PIN         2'h1
`define PMC_MODE_SOFT        2'h2
`define PMC_STEP_LAST        3'h7
`define PMC_CLK_PERIOD_NS    50
`define PMC_NS_PER_US        1000
`define PMC_US_PER_MS        1000
`define PMC_VCO_WAIT0_US     20
`define PMC_VCO_WAIT1_US     400
`define PMC_VCO_WAIT2_US     8000
`define PMC_VCO_WAIT3_US     200000
`define PMC_CLSD_WAIT0_US    30
`define PMC_CLSD_WAIT1_US    300
`define PMC_CLSD_WAIT2_MS    30
`define PMC_CLSD_WAIT3_MS    300
`endif

//--- inc/pmc_pkg.sv
// Types shared by the register slice and its calibration sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package pmc_pkg;
   typedef enum logic [1:0] {S_IDLE, S_VCO, S_CLSD} pmc_seq_state_t;
   typedef logic [1:0]  pmc_wait_code_t;
   typedef logic [18:0] pmc_us_count_t;
endpackage : pmc_pkg

//--- inc/pmc_cal_if.sv
// Carrier between the register slice and the calibration sequencer.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
interface pmc_cal_if;
   pmc_pkg::pmc_wait_code_t vco_code;
   pmc_pkg::pmc_wait_code_t clsd_code;
   logic                    start;
   logic                    busy;
   logic                    done;
   modport ctrl (output vco_code, output clsd_code, output start, input busy, input done);
   modport seq  (input vco_code, input clsd_code, input start, output busy, output done);
endinterface : pmc_cal_if
`default_nettype wire

//--- verilog/pmc_cal_seq.sv
// Calibration sequencer: VCO settle wait followed by closed-loop settle wait.
// Assumes a single clock and an active-low asynchronous reset shared with the register slice.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"
module pmc_cal_seq #(
   parameter int CYC_PER_US = `PMC_NS_PER_US / `PMC_CLK_PERIOD_NS,
   parameter int VCO_US0    = `PMC_VCO_WAIT0_US,
   parameter int VCO_US1    = `PMC_VCO_WAIT1_US,
   parameter int VCO_US2    = `PMC_VCO_WAIT2_US,
   parameter int VCO_US3    = `PMC_VCO_WAIT3_US,
   parameter int CLSD_US0   = `PMC_CLSD_WAIT0_US,
   parameter int CLSD_US1   = `PMC_CLSD_WAIT1_US,
   parameter int CLSD_US2   = `PMC_CLSD_WAIT2_MS * `PMC_US_PER_MS,
   parameter int CLSD_US3   = `PMC_CLSD_WAIT3_MS * `PMC_US_PER_MS
) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   pmc_cal_if.seq    cal
);
   pmc_pkg::pmc_seq_state_t state_reg, state_next;
   pmc_pkg::pmc_us_count_t  cnt_reg,   cnt_next;
   pmc_pkg::pmc_wait_code_t clsd_reg,  clsd_next;
   logic [7:0]              pre_reg,   pre_next;
   logic                    busy_reg,  busy_next;
   logic                    done_reg,  done_next;
   logic                    tick;

   function automatic pmc_pkg::pmc_us_count_t vco_us(input pmc_pkg::pmc_wait_code_t c);
      case (c)
         2'h0:    vco_us = 19'(VCO_US0);
         2'h1:    vco_us = 19'(VCO_US1);
         2'h2:    vco_us = 19'(VCO_US2);
         default: vco_us = 19'(VCO_US3);
      endcase
   endfunction : vco_us

   function automatic pmc_pkg::pmc_us_count_t clsd_us(input pmc_pkg::pmc_wait_code_t c);
      case (c)
         2'h0:    clsd_us = 19'(CLSD_US0);
         2'h1:    clsd_us = 19'(CLSD_US1);
         2'h2:    clsd_us = 19'(CLSD_US2);
         default: clsd_us = 19'(CLSD_US3);
      endcase
   endfunction : clsd_us

   assign tick     = (pre_reg == 8'(CYC_PER_US - 1));
   assign cal.busy = busy_reg;
   assign cal.done = done_reg;

   // Codes are latched at start so a rewrite mid-sequence cannot shorten a wait.
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      clsd_next  = clsd_reg;
      pre_next   = tick ? 8'h00 : pre_reg + 8'h01;
      done_next  = 1'b0;
      case (state_reg)
         pmc_pkg::S_IDLE: begin
            pre_next = 8'h00;
            if (cal.start) begin
               state_next = pmc_pkg::S_VCO;
               cnt_next   = vco_us(cal.vco_code);
               clsd_next  = cal.clsd_code;
            end
         end
         pmc_pkg::S_VCO: begin
            if (tick) begin
               if (cnt_reg == 19'h0_0001) begin
                  state_next = pmc_pkg::S_CLSD;
                  cnt_next   = clsd_us(clsd_reg);
               end else begin
                  cnt_next = cnt_reg - 19'h0_0001;
               end
            end
         end
         default: begin
            if (tick) begin
               if (cnt_reg == 19'h0_0001) begin
                  state_next = pmc_pkg::S_IDLE;
                  done_next  = 1'b1;
               end else begin
                  cnt_next = cnt_reg - 19'h0_0001;
               end
            end
         end
      endcase
      busy_next = (state_next != pmc_pkg::S_IDLE);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= pmc_pkg::S_IDLE;
         cnt_reg   <= 19'h0_0000;
         clsd_reg  <= 2'h0;
         pre_reg   <= 8'h00;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         clsd_reg  <= clsd_next;
         pre_reg   <= pre_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
      end
   end

   logic [23:0] elapsed_reg;
   logic [23:0] total_reg;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         elapsed_reg <= 24'h00_0000;
         total_reg   <= 24'h00_0000;
      end else if (state_reg == pmc_pkg::S_IDLE) begin
         elapsed_reg <= 24'h00_0000;
         if (cal.start) begin
            total_reg <= 24'((int'(vco_us(cal.vco_code)) + int'(clsd_us(cal.clsd_code)))
                             * CYC_PER_US);
         end
      end else begin
         elapsed_reg <= elapsed_reg + 24'h00_0001;
      end
   end

   sequence s_cal_start;
      state_reg == pmc_pkg::S_IDLE && cal.start;
   endsequence

   a_cal_total_time: assert property (@(posedge clk_sys) disable iff (!resetn)
      done_reg |-> elapsed_reg == total_reg)
      else $error("Calibration ended after the wrong number of cycles.");
   a_cal_busy_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_cal_start |=> busy_reg [*8])
      else $error("Calibration busy dropped too early.");
endmodule : pmc_cal_seq
`default_nettype wire

//--- verilog/pmc_cal_regs.sv
// PLL margin and calibration configuration registers with margining selector.
// Assumes the serial register engine presents one-cycle read and write strobes on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"
module pmc_cal_regs #(
   parameter int STEP_COUNT = 8,
   parameter int OFFSET_W   = 10,
   parameter int CYC_PER_US = `PMC_NS_PER_US / `PMC_CLK_PERIOD_NS,
   parameter int VCO_US0    = `PMC_VCO_WAIT0_US,
   parameter int VCO_US1    = `PMC_VCO_WAIT1_US,
   parameter int VCO_US2    = `PMC_VCO_WAIT2_US,
   parameter int VCO_US3    = `PMC_VCO_WAIT3_US,
   parameter int CLSD_US0   = `PMC_CLSD_WAIT0_US,
   parameter int CLSD_US1   = `PMC_CLSD_WAIT1_US,
   parameter int CLSD_US2   = `PMC_CLSD_WAIT2_MS * `PMC_US_PER_MS,
   parameter int CLSD_US3   = `PMC_CLSD_WAIT3_MS * `PMC_US_PER_MS
) (
   input  wire logic                                clk_sys,
   input  wire logic                                resetn,
   input  wire logic                                reg_wr_en,
   input  wire logic                                reg_rd_en,
   input  wire logic [7:0]                          reg_addr,
   input  wire logic [7:0]                          reg_wdata,
   output logic      [7:0]                          reg_rdata,
   input  wire logic [1:0]                          margin_mode_sel,
   input  wire logic                                margin_step_pin,
   input  wire logic                                margin_aux_pin,
   input  wire logic [1:0]                          margin_step8_offset_high,
   input  wire logic [(STEP_COUNT-1)*OFFSET_W-1:0]  margin_step_offsets,
   output logic      [OFFSET_W-1:0]                 margin_offset,
   output logic                                     margin_enable,
   output logic      [2:0]                          margin_step_index,
   output logic                                     pd_pulse_stretch,
   output logic      [2:0]                          loop_filter_order_sel,
   output logic      [1:0]                          vco_settle_wait,
   output logic      [1:0]                          closed_loop_settle_wait,
   input  wire logic                                cal_start,
   output logic                                     cal_busy,
   output logic                                     cal_done
);
   logic [7:0]          step8_low_reg,  step8_low_next;
   logic [1:0]          soft_high_reg,  soft_high_next;
   logic [7:0]          soft_low_reg,   soft_low_next;
   logic                stretch_reg,    stretch_next;
   logic [2:0]          filter_reg,     filter_next;
   logic [1:0]          clsd_reg,       clsd_next;
   logic [1:0]          vco_reg,        vco_next;
   logic [7:0]          rdata_reg,      rdata_next;
   logic [OFFSET_W-1:0] offset_reg,     offset_next;
   logic                enable_reg,     enable_next;
   logic [2:0]          idx_reg,        idx_next;
   logic                pin_prev_reg,   pin_prev_next;
   logic [OFFSET_W-1:0] soft_offset;
   logic [OFFSET_W-1:0] step_offset;

   pmc_cal_if cal_if ();

   pmc_cal_seq #(
      .CYC_PER_US (CYC_PER_US),
      .VCO_US0    (VCO_US0),
      .VCO_US1    (VCO_US1),
      .VCO_US2    (VCO_US2),
      .VCO_US3    (VCO_US3),
      .CLSD_US0   (CLSD_US0),
      .CLSD_US1   (CLSD_US1),
      .CLSD_US2   (CLSD_US2),
      .CLSD_US3   (CLSD_US3)
   ) u_seq (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .cal     (cal_if.seq)
   );

   assign cal_if.vco_code  = vco_reg;
   assign cal_if.clsd_code = clsd_reg;
   assign cal_if.start     = cal_start;
   assign cal_busy         = cal_if.busy;
   assign cal_done         = cal_if.done;

   assign reg_rdata               = rdata_reg;
   assign margin_offset           = offset_reg;
   assign margin_enable           = enable_reg;
   assign margin_step_index       = idx_reg;
   assign pd_pulse_stretch        = stretch_reg;
   assign loop_filter_order_sel   = filter_reg;
   assign vco_settle_wait         = vco_reg;
   assign closed_loop_settle_wait = clsd_reg;

   assign soft_offset = {soft_high_reg, soft_low_reg};

   // Steps one to seven live in neighbouring registers; the eighth keeps its low byte here and takes its high bits from margin_step8_offset_high.
   function automatic logic [OFFSET_W-1:0] step_pick(input logic [2:0] idx);
      if (idx == `PMC_STEP_LAST) begin
         step_pick = {margin_step8_offset_high, step8_low_reg};
      end else begin
         step_pick = margin_step_offsets[idx*OFFSET_W +: OFFSET_W];
      end
   endfunction : step_pick

   assign step_offset = step_pick(idx_reg);

   always_comb begin
      step8_low_next = step8_low_reg;
      soft_high_next = soft_high_reg;
      soft_low_next  = soft_low_reg;
      stretch_next   = stretch_reg;
      filter_next    = filter_reg;
      clsd_next      = clsd_reg;
      vco_next       = vco_reg;
      if (reg_wr_en) begin
         if (reg_addr == `PMC_ADDR_STEP8_LOW) begin
            step8_low_next = reg_wdata;
         end else if (reg_addr == `PMC_ADDR_SOFT_HIGH) begin
            soft_high_next = reg_wdata[`PMC_SOFT_HIGH_MSB:0];
         end else if (reg_addr == `PMC_ADDR_SOFT_LOW) begin
            soft_low_next = reg_wdata;
         end else if (reg_addr == `PMC_ADDR_STRETCH) begin
            stretch_next = reg_wdata[`PMC_STRETCH_BIT];
         end else if (reg_addr == `PMC_ADDR_FILTER) begin
            // Reserved codes are stored as written; the filter treats them as undefined.
            filter_next = reg_wdata[`PMC_FILTER_MSB:0];
         end else if (reg_addr == `PMC_ADDR_CAL_WAIT) begin
            clsd_next = reg_wdata[`PMC_CLSD_MSB:`PMC_CLSD_LSB];
            vco_next  = reg_wdata[`PMC_VCO_MSB:`PMC_VCO_LSB];
         end
      end
   end

   // Reads answer one cycle later; reserved bits and unmapped offsets read zero.
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_en) begin
         if (reg_addr == `PMC_ADDR_STEP8_LOW) begin
            rdata_next = step8_low_reg;
         end else if (reg_addr == `PMC_ADDR_SOFT_HIGH) begin
            rdata_next = {6'h00, soft_high_reg};
         end else if (reg_addr == `PMC_ADDR_SOFT_LOW) begin
            rdata_next = soft_low_reg;
         end else if (reg_addr == `PMC_ADDR_STRETCH) begin
            rdata_next = {stretch_reg, 7'h00};
         end else if (reg_addr == `PMC_ADDR_FILTER) begin
            rdata_next = {5'h00, filter_reg};
         end else if (reg_addr == `PMC_ADDR_CAL_WAIT) begin
            rdata_next = {4'h0, clsd_reg, vco_reg};
         end else begin
            rdata_next = `PMC_RD_ZERO;
         end
      end
   end

   // The auxiliary pin is deliberately unused: in pin mode its state does not matter.
   always_comb begin
      pin_prev_next = margin_step_pin;
      idx_next      = idx_reg;
      offset_next   = {OFFSET_W{1'b0}};
      enable_next   = 1'b0;
      if (margin_mode_sel == `PMC_MODE_SOFT) begin
         offset_next = soft_offset;
         enable_next = 1'b1;
      end else if (margin_mode_sel == `PMC_MODE_PIN) begin
         if (margin_step_pin && !pin_prev_reg) begin
            idx_next = idx_reg + 3'h1;
         end
         offset_next = step_offset;
         enable_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         step8_low_reg <= `PMC_RST_STEP8_LOW;
         soft_high_reg <= `PMC_RST_SOFT_HIGH;
         soft_low_reg  <= `PMC_RST_SOFT_LOW;
         stretch_reg   <= `PMC_RST_STRETCH;
         filter_reg    <= `PMC_RST_FILTER;
         clsd_reg      <= `PMC_RST_CLSD_WAIT;
         vco_reg       <= `PMC_RST_VCO_WAIT;
         rdata_reg     <= `PMC_RD_ZERO;
         offset_reg    <= {OFFSET_W{1'b0}};
         enable_reg    <= 1'b0;
         idx_reg       <= 3'h0;
         pin_prev_reg  <= 1'b0;
      end else begin
         step8_low_reg <= step8_low_next;
         soft_high_reg <= soft_high_next;
         soft_low_reg  <= soft_low_next;
         stretch_reg   <= stretch_next;
         filter_reg    <= filter_next;
         clsd_reg      <= clsd_next;
         vco_reg       <= vco_next;
         rdata_reg     <= rdata_next;
         offset_reg    <= offset_next;
         enable_reg    <= enable_next;
         idx_reg       <= idx_next;
         pin_prev_reg  <= pin_prev_next;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_write(logic [7:0] a);
      reg_wr_en && reg_addr == a;
   endsequence

   a_step8_write: assert property (s_write(`PMC_ADDR_STEP8_LOW) |=>
      step8_low_reg == $past(reg_wdata))
      else $error("Step eight low byte did not take the written value.");
   a_soft_high_write: assert property (s_write(`PMC_ADDR_SOFT_HIGH) |=>
      soft_offset[9:8] == $past(reg_wdata[1:0]))
      else $error("Software offset high bits wrong after write.");
   a_stretch_out: assert property (s_write(`PMC_ADDR_STRETCH) |=>
      pd_pulse_stretch == $past(reg_wdata[7]))
      else $error("Pulse stretch output did not follow bit seven.");
   a_filter_readback: assert property (reg_rd_en && reg_addr == `PMC_ADDR_FILTER |=>
      reg_rdata == {5'h00, $past(loop_filter_order_sel)})
      else $error("Loop filter readback mismatch.");
   a_clsd_field: assert property (s_write(`PMC_ADDR_CAL_WAIT) |=>
      closed_loop_settle_wait == $past(reg_wdata[3:2]))
      else $error("Closed-loop wait code wrong after write.");
   a_vco_field: assert property (s_write(`PMC_ADDR_CAL_WAIT) |=>
      vco_settle_wait == $past(reg_wdata[1:0]))
      else $error("VCO wait code wrong after write.");
   a_soft_select: assert property (margin_mode_sel == `PMC_MODE_SOFT |=>
      margin_enable && margin_offset == $past(soft_offset))
      else $error("Software mode did not route the software offset.");
   a_pin_select: assert property (margin_mode_sel == `PMC_MODE_PIN |=>
      margin_enable && margin_offset == $past(step_offset))
      else $error("Pin mode did not route the selected step.");
endmodule : pmc_cal_regs
`default_nettype wire

//--- verif/pmc_cal_regs_tb_top.sv
// Self-checking bench for the PLL margin and calibration register slice.
// Assumes pmc_cal_regs behind its strobe register port, with shortened wait parameters.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"
module pmc_cal_regs_tb_top;
   // Short waits keep the run small; every expected wait is derived from these.
   localparam int CPU     = 2;
   localparam int VUS [4] = '{1, 2, 3, 4};
   localparam int CUS [4] = '{1, 2, 3, 5};

   logic        clk_sys;
   logic        resetn;
   logic        reg_wr_en;
   logic        reg_rd_en;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [1:0]  margin_mode_sel;
   logic        margin_step_pin;
   logic        margin_aux_pin;
   logic [1:0]  margin_step8_offset_high;
   logic [69:0] margin_step_offsets;
   logic [9:0]  margin_offset;
   logic        margin_enable;
   logic [2:0]  margin_step_index;
   logic        pd_pulse_stretch;
   logic [2:0]  loop_filter_order_sel;
   logic [1:0]  vco_settle_wait;
   logic [1:0]  closed_loop_settle_wait;
   logic        cal_start;
   logic        cal_busy;
   logic        cal_done;
   logic [7:0]  step8_low;
   int          n_errors;
   int          n_checks;
   int          cyc;
   int          t0;
   int          exp_idx;
   int          i;

   pmc_cal_regs #(.CYC_PER_US(CPU), .VCO_US0(VUS[0]), .VCO_US1(VUS[1]), .VCO_US2(VUS[2]),
      .VCO_US3(VUS[3]), .CLSD_US0(CUS[0]), .CLSD_US1(CUS[1]), .CLSD_US2(CUS[2]),
      .CLSD_US3(CUS[3])) pmc_cal_regs_inst (
      .clk_sys(clk_sys), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .margin_mode_sel(margin_mode_sel), .margin_step_pin(margin_step_pin),
      .margin_aux_pin(margin_aux_pin), .margin_step8_offset_high(margin_step8_offset_high),
      .margin_step_offsets(margin_step_offsets), .margin_offset(margin_offset),
      .margin_enable(margin_enable), .margin_step_index(margin_step_index),
      .pd_pulse_stretch(pd_pulse_stretch), .loop_filter_order_sel(loop_filter_order_sel),
      .vco_settle_wait(vco_settle_wait), .closed_loop_settle_wait(closed_loop_settle_wait),
      .cal_start(cal_start), .cal_busy(cal_busy), .cal_done(cal_done));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic end_of_test;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   // The run needs under four hundred cycles; the ceiling leaves ample margin.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, cyc, 20000);
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr_en <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd_en <= 1'b1;
      reg_addr  <= a;
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
      @(negedge clk_sys);
      chk(reg_rdata, e);
   endtask : rd

   task automatic set_mode(input logic [1:0] m);
      @(posedge clk_sys);
      margin_mode_sel <= m;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : set_mode

   // The aux pin toggles on every pulse so that any use of it shows up.
   task automatic pulse_pin;
      @(posedge clk_sys);
      margin_step_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      margin_step_pin <= 1'b0;
      margin_aux_pin  <= ~margin_aux_pin;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : pulse_pin

   function automatic logic [9:0] step_val(input int k);
      if (k == 7) begin
         return {margin_step8_offset_high, step8_low};
      end
      return 10'((k + 1) * 97 + 5);
   endfunction : step_val

   task automatic do_reset;
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      exp_idx   = 0;
      step8_low = 8'h9E;
   endtask : do_reset

   task automatic chk_reset;
      rd(`PMC_ADDR_STEP8_LOW, 8'h9E);
      rd(`PMC_ADDR_SOFT_HIGH, 8'h00);
      rd(`PMC_ADDR_SOFT_LOW, 8'h00);
      rd(`PMC_ADDR_STRETCH, 8'h00);
      rd(`PMC_ADDR_FILTER, 8'h03);
      rd(`PMC_ADDR_CAL_WAIT, 8'h01);
      chk(pd_pulse_stretch, 16'h0000);
      chk(loop_filter_order_sel, 16'h0003);
      chk(vco_settle_wait, 16'h0001);
      chk(closed_loop_settle_wait, 16'h0000);
      $display("test reset_values finished");
   endtask : chk_reset

   // Wait codes are latched at start, so a rewrite or a second start mid-run changes nothing.
   task automatic cal_run(input int v, input int c, input bit mid);
      wr(`PMC_ADDR_CAL_WAIT, {4'h0, 2'(c), 2'(v)});
      @(posedge clk_sys);
      cal_start <= 1'b1;
      @(posedge clk_sys);
      cal_start <= 1'b0;
      #1 t0 = cyc;
      @(negedge clk_sys);
      chk({cal_busy, cal_done}, 16'h0002);
      if (mid) begin
         wr(`PMC_ADDR_CAL_WAIT, 8'h00);
         @(posedge clk_sys);
         cal_start <= 1'b1;
         @(posedge clk_sys);
         cal_start <= 1'b0;
      end
      for (int k = 0; k < 400 && cal_done !== 1'b1; k++) @(negedge clk_sys);
      chk(16'(cyc - t0), 16'((VUS[v] + CUS[c]) * CPU));
      chk({cal_busy, cal_done}, 16'h0001);
      @(negedge clk_sys);
      chk({cal_busy, cal_done}, 16'h0000);
   endtask : cal_run

   initial begin
      resetn = 1'b0;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      margin_mode_sel = 2'h0;
      margin_step_pin = 1'b0;
      margin_aux_pin = 1'b0;
      margin_step8_offset_high = 2'h2;
      cal_start = 1'b0;
      n_errors = 0;
      n_checks = 0;
      cyc = 0;
      for (i = 1; i < 8; i++) margin_step_offsets[(i-1)*10 +: 10] = 10'(i * 97 + 5);
      do_reset();
      chk_reset();
      wr(`PMC_ADDR_STEP8_LOW, 8'h5A);
      step8_low = 8'h5A;
      rd(`PMC_ADDR_STEP8_LOW, 8'h5A);
      wr(`PMC_ADDR_SOFT_HIGH, 8'hFF);
      rd(`PMC_ADDR_SOFT_HIGH, 8'h03);
      wr(`PMC_ADDR_SOFT_LOW, 8'hA5);
      rd(`PMC_ADDR_SOFT_LOW, 8'hA5);
      wr(`PMC_ADDR_STRETCH, 8'hFF);
      rd(`PMC_ADDR_STRETCH, 8'h80);
      chk(pd_pulse_stretch, 16'h0001);
      wr(`PMC_ADDR_STRETCH, 8'h7F);
      rd(`PMC_ADDR_STRETCH, 8'h00);
      chk(pd_pulse_stretch, 16'h0000);
      for (i = 0; i < 8; i++) begin
         wr(`PMC_ADDR_FILTER, 8'(8'hF8 | i));
         rd(`PMC_ADDR_FILTER, 8'(i));
         chk(loop_filter_order_sel, 16'(i));
      end
      for (i = 0; i < 16; i++) begin
         wr(`PMC_ADDR_CAL_WAIT, 8'(8'hF0 | i));
         rd(`PMC_ADDR_CAL_WAIT, 8'(i));
         chk(vco_settle_wait, 16'(i % 4));
         chk(closed_loop_settle_wait, 16'(i / 4));
      end
      wr(8'h70, 8'h55);
      rd(8'h70, 8'h00);
      $display("test registers finished");
      set_mode(2'h2);
      chk({margin_enable, 5'h00, margin_offset}, 16'h83A5);
      wr(`PMC_ADDR_SOFT_HIGH, 8'h01);
      wr(`PMC_ADDR_SOFT_LOW, 8'h3C);
      repeat (2) @(negedge clk_sys);
      chk(margin_offset, 16'h013C);
      pulse_pin();
      chk(margin_step_index, 16'h0000);
      set_mode(2'h1);
      for (i = 0; i < 9; i++) begin
         chk(margin_step_index, 16'(exp_idx));
         chk({margin_enable, 5'h00, margin_offset}, {6'h20, step_val(exp_idx)});
         pulse_pin();
         exp_idx = (exp_idx + 1) % 8;
      end
      set_mode(2'h0);
      chk({margin_enable, 5'h00, margin_offset}, 16'h0000);
      set_mode(2'h3);
      chk({margin_enable, 5'h00, margin_offset}, 16'h0000);
      $display("test margining finished");
      for (i = 0; i < 4; i++) cal_run(i, 3 - i, 1'b0);
      cal_run(1, 1, 1'b0);
      cal_run(3, 3, 1'b1);
      rd(`PMC_ADDR_CAL_WAIT, 8'h00);
      $display("test calibration finished");
      do_reset();
      chk_reset();
      end_of_test();
   end
endmodule : pmc_cal_regs_tb_top
`default_nettype wire
